// ### lcd_segment_loader_serial_slave.sv
// Serial slave that loads the display store and drives the segment and backplane lines.
//
// Contract
// - Low subaddress bit reads 0 when pin is oscillator or grounded, 1 at supply.
// - Direct mode: shared pin is only high subaddress bit, pulled low when open.
// - Duplex mode: pin drives second backplane; select from low two subaddress bits.
// - Oscillator pin strapped to a rail means cascade: timing follows backplane inputs.
// - One control register plus eight segment bytes; even bank A, odd bank B.
// - Every address-matched device stores the second byte as control.
// - Upper vector bits must match subaddress to accept data; otherwise ignore, stay active.
// - Lower three vector bits pick the segment register for the next byte.
// - Mode bit 0 gives direct drive, four bytes for 32 segments.
// - Direct drive shows even registers for bank 0, odd for bank 1.
// - Direct drive advances the vector by two per data byte, stored or not.
// - Either bank may be written whichever bank is shown.
// - Mode bit 1 selects duplex drive with two backplanes.
// - Duplex mode advances the vector by one per byte.
// - Duplex mode shows all eight bytes and ignores the bank bit.
// - Vector increments including device bits, crossing into the next chip.
// - The six-bit vector wraps from all ones to all zeros.
// - Reset floats both backplanes in master and cascade mode, and grounds segments.
// - Reset clears control and segment registers and idles the serial interface.
// - First byte after start is the address; all matching receivers acknowledge it.
// - Every addressed device acknowledges the control byte.
// - Only the vector-selected device acknowledges segment data bytes.
// - Any number of data bytes; stop ends loading.
// - Direct drive uses the first backplane for every segment byte.
// - Duplex: even registers against first backplane, odd against second.
// - Acknowledge holds data low across the whole acknowledge clock high phase.
`timescale 1ns/10ps

module lcd_segment_loader_serial_slave (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic osc_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic rc_osc_used_i,
    input wire logic subaddr_low_bit_rc_pin_i,
    input wire logic subaddr_mid_bit_i,
    input wire logic subaddr_high_bit_or_second_backplane_i,
    output logic subaddr_high_bit_or_second_backplane_o,
    output logic subaddr_high_bit_or_second_backplane_oe_o,
    input wire logic first_backplane_out_i,
    output logic first_backplane_out_o,
    output logic first_backplane_out_oe_o,
    output logic [31:0] segment_o
);

    // ****************************************************************
    // Pin synchronisers on the system clock
    // ****************************************************************
    logic [7:0] pin_raw;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] pin_s3;
    logic [7:0] pin_f;
    logic [7:0] next_pin_f;
    logic ack_tgl;

    assign pin_raw = {1'b0, ack_tgl, scl_i, sda_i, rc_osc_used_i, subaddr_low_bit_rc_pin_i,
                      subaddr_mid_bit_i, subaddr_high_bit_or_second_backplane_i};
    assign next_pin_f = lcd_loader_pkg::agree_filter(pin_s2, pin_s3, pin_f);

    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            // Stages start at the idle bus levels so that release shows no false edge.
            pin_s1 <= 8'h30;
            pin_s2 <= 8'h30;
            pin_s3 <= 8'h30;
            pin_f <= 8'h30;
        end
        else
        begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_f <= next_pin_f;
        end
    end

    wire ack_tgl_f = pin_f[6];
    wire scl_f = pin_f[5];
    wire sda_f = pin_f[4];
    wire rc_used_f = pin_f[3];
    wire subaddr_low = rc_used_f ? 1'b0 : pin_f[2];
    wire subaddr_mid = pin_f[1];
    wire subaddr_high = pin_f[0];

    // ****************************************************************
    // Bus condition detection
    // ****************************************************************
    logic scl_d;
    logic sda_d;

    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end

    wire scl_rise = scl_f & ~scl_d;
    wire scl_fall = ~scl_f & scl_d;
    wire start_seen = scl_f & scl_d & sda_d & ~sda_f;
    wire stop_seen = scl_f & scl_d & ~sda_d & sda_f;

    // ****************************************************************
    // Registers and address decode
    // ****************************************************************
    lcd_loader_pkg::bus_state_t state;
    lcd_loader_pkg::bus_state_t next_state;
    logic [7:0] display_control;
    logic [7:0][7:0] segment_store;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic ack_phase;

    wire mode = display_control[lcd_loader_pkg::CTRL_MODE_BIT];
    wire bank = display_control[lcd_loader_pkg::CTRL_BANK_BIT];
    wire [5:0] vector = display_control[lcd_loader_pkg::VEC_MSB:0];
    wire [2:0] device_select_bits = vector[lcd_loader_pkg::VEC_MSB:lcd_loader_pkg::DEV_SEL_LSB];
    wire [2:0] register_select_bits = vector[lcd_loader_pkg::REG_SEL_MSB:0];
    wire duplex = (mode == lcd_loader_pkg::MODE_DUPLEX);

    // Duplex compares only two bits because the high pin is then an output.
    wire sel_direct = (device_select_bits == {subaddr_high, subaddr_mid, subaddr_low});
    wire sel_duplex = (device_select_bits[1:0] == {subaddr_mid, subaddr_low});
    wire selected = duplex ? sel_duplex : sel_direct;

    wire [5:0] step = duplex ? lcd_loader_pkg::STEP_DUPLEX : lcd_loader_pkg::STEP_DIRECT;
    wire [5:0] next_vector = 6'(vector + step);

    wire byte_done = scl_fall & ~ack_phase & (bit_cnt == lcd_loader_pkg::BYTE_BITS);
    wire addr_hit = (shift[7:1] == lcd_loader_pkg::SLAVE_ADDR) & ~shift[0];
    wire in_addr = (state == lcd_loader_pkg::ST_ADDR);
    wire in_ctrl = (state == lcd_loader_pkg::ST_CTRL);
    wire in_data = (state == lcd_loader_pkg::ST_DATA);
    wire take_ctrl = byte_done & in_ctrl;
    wire take_data = byte_done & in_data;
    wire store_seg = take_data & selected;
    wire give_ack = (in_addr & addr_hit) | in_ctrl | (in_data & selected);

    always_comb
    begin
        next_state = state;
        if (start_seen)
        begin
            next_state = lcd_loader_pkg::ST_ADDR;
        end
        else if (stop_seen)
        begin
            next_state = lcd_loader_pkg::ST_IDLE;
        end
        else if (byte_done)
        begin
            case (state)
                lcd_loader_pkg::ST_ADDR: next_state = addr_hit ? lcd_loader_pkg::ST_CTRL
                                                               : lcd_loader_pkg::ST_IDLE;
                lcd_loader_pkg::ST_CTRL: next_state = lcd_loader_pkg::ST_DATA;
                lcd_loader_pkg::ST_DATA: next_state = lcd_loader_pkg::ST_DATA;
                default: next_state = lcd_loader_pkg::ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Serial receiver
    // ****************************************************************
    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            state <= lcd_loader_pkg::ST_IDLE;
            shift <= 8'h00;
            bit_cnt <= lcd_loader_pkg::BIT_COUNT_RESET;
            ack_phase <= 1'b0;
            sda_oe_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (start_seen || stop_seen)
            begin
                bit_cnt <= lcd_loader_pkg::BIT_COUNT_RESET;
                ack_phase <= 1'b0;
                sda_oe_o <= 1'b0;
            end
            else if (byte_done && state != lcd_loader_pkg::ST_IDLE)
            begin
                ack_phase <= 1'b1;
                sda_oe_o <= give_ack;
            end
            else if (scl_fall && ack_phase)
            begin
                // Released only after the acknowledge pulse has fallen again.
                ack_phase <= 1'b0;
                sda_oe_o <= 1'b0;
                bit_cnt <= lcd_loader_pkg::BIT_COUNT_RESET;
            end
            else if (scl_rise && !ack_phase && bit_cnt != lcd_loader_pkg::BYTE_BITS)
            begin
                shift <= {shift[6:0], sda_f};
                bit_cnt <= 4'(bit_cnt + 4'h1);
            end
        end
    end

    assign sda_o = 1'b0;

    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            display_control <= lcd_loader_pkg::CTRL_RESET;
            segment_store <= {8{lcd_loader_pkg::SEG_RESET}};
        end
        else if (take_ctrl)
        begin
            display_control <= shift;
        end
        else if (take_data)
        begin
            // Every addressed chip steps the vector so that selection can pass on.
            display_control[lcd_loader_pkg::VEC_MSB:0] <= next_vector;
            if (store_seg)
            begin
                segment_store[register_select_bits] <= shift;
            end
        end
    end

    // ****************************************************************
    // Image handover to the oscillator domain
    // ****************************************************************
    lcd_loader_pkg::display_image_t snap;
    logic req_tgl;
    logic dirty;

    // The snapshot only changes while no request is open, so it is stable when sampled.
    wire launch = dirty & (req_tgl == ack_tgl_f);
    wire touched = take_ctrl | store_seg;

    always_ff @(posedge sys_clk_i)
    begin
        if (!reset_n_i)
        begin
            snap <= lcd_loader_pkg::IMAGE_RESET;
            req_tgl <= 1'b0;
            dirty <= 1'b0;
        end
        else
        begin
            dirty <= touched | (dirty & ~launch);
            if (launch)
            begin
                snap <= '{mode: mode, bank: bank, seg: segment_store};
                req_tgl <= ~req_tgl;
            end
        end
    end

    // ****************************************************************
    // Oscillator domain: reset and synchronisers
    // ****************************************************************
    logic lrst_s1;
    logic lrst_s2;

    always_ff @(posedge osc_clk_i)
    begin
        lrst_s1 <= reset_n_i;
        lrst_s2 <= lrst_s1;
    end

    logic [7:0] lin_raw;
    logic [7:0] lin_s1;
    logic [7:0] lin_s2;
    logic [7:0] lin_s3;
    logic [7:0] lin_f;
    logic [7:0] next_lin_f;

    assign lin_raw = {4'h0, rc_osc_used_i, first_backplane_out_i,
                      subaddr_high_bit_or_second_backplane_i, req_tgl};
    assign next_lin_f = lcd_loader_pkg::agree_filter(lin_s2, lin_s3, lin_f);

    always_ff @(posedge osc_clk_i)
    begin
        if (!lrst_s2)
        begin
            lin_s1 <= 8'h00;
            lin_s2 <= 8'h00;
            lin_s3 <= 8'h00;
            lin_f <= 8'h00;
        end
        else
        begin
            lin_s1 <= lin_raw;
            lin_s2 <= lin_s1;
            lin_s3 <= lin_s2;
            lin_f <= next_lin_f;
        end
    end

    wire cascade = ~lin_f[3];
    wire ext_bp1 = lin_f[2];
    wire ext_bp2 = lin_f[1];
    wire req_f = lin_f[0];

    // ****************************************************************
    // Oscillator domain: image capture and drive timing
    // ****************************************************************
    lcd_loader_pkg::display_image_t image;
    logic [7:0] div_cnt;
    logic [1:0] own_slot;

    wire div_wrap = (div_cnt == 8'(lcd_loader_pkg::FRAME_DIV_CYCLES - 8'h01));

    always_ff @(posedge osc_clk_i)
    begin
        if (!lrst_s2)
        begin
            image <= lcd_loader_pkg::IMAGE_RESET;
            ack_tgl <= 1'b0;
            div_cnt <= lcd_loader_pkg::FRAME_DIV_RESET;
            own_slot <= lcd_loader_pkg::SLOT_RESET;
        end
        else
        begin
            if (req_f != ack_tgl)
            begin
                image <= snap;
                ack_tgl <= req_f;
            end
            div_cnt <= div_wrap ? lcd_loader_pkg::FRAME_DIV_RESET : 8'(div_cnt + 8'h01);
            if (div_wrap)
            begin
                own_slot <= 2'(own_slot + 2'h1);
            end
        end
    end

    // A cascaded chip takes its drive phase from the shared backplane lines.
    wire [1:0] slot = cascade ? {ext_bp2, ext_bp1} : own_slot;
    wire phase = slot[0];
    wire img_duplex = (image.mode == lcd_loader_pkg::MODE_DUPLEX);
    wire second_half = slot[1];
    wire pick_odd = img_duplex ? second_half : image.bank;
    wire [31:0] shown = lcd_loader_pkg::pick_bytes(image.seg, pick_odd);
    wire [31:0] next_segment = shown ^ {32{phase}};
    wire next_bp1 = img_duplex ? (~second_half & phase) : phase;
    wire next_bp2 = img_duplex & second_half & phase;

    always_ff @(posedge osc_clk_i)
    begin
        if (!lrst_s2)
        begin
            segment_o <= lcd_loader_pkg::SEGMENT_RESET;
            first_backplane_out_o <= 1'b0;
            subaddr_high_bit_or_second_backplane_o <= 1'b0;
            first_backplane_out_oe_o <= 1'b0;
            subaddr_high_bit_or_second_backplane_oe_o <= 1'b0;
        end
        else
        begin
            segment_o <= next_segment;
            first_backplane_out_o <= next_bp1;
            subaddr_high_bit_or_second_backplane_o <= next_bp2;
            first_backplane_out_oe_o <= ~cascade;
            subaddr_high_bit_or_second_backplane_oe_o <= ~cascade & img_duplex;
        end
    end

endmodule : lcd_segment_loader_serial_slave

// ### lcd_loader_pkg.sv
// Constants, types and helpers shared by the display-store serial loader.
package lcd_loader_pkg;

    // ****************************************************************
    // Serial bus framing
    // ****************************************************************
    // The slave address value is arbitrary; replace it for the target system.
    localparam logic [6:0] SLAVE_ADDR = 7'h3A;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] BIT_COUNT_RESET = 4'h0;

    // ****************************************************************
    // Control byte layout and reset values
    // ****************************************************************
    localparam int CTRL_MODE_BIT = 7;
    localparam int CTRL_BANK_BIT = 6;
    localparam int VEC_MSB = 5;
    localparam int DEV_SEL_LSB = 3;
    localparam int REG_SEL_MSB = 2;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] SEG_RESET = 8'h00;
    localparam logic MODE_DIRECT = 1'b0;
    localparam logic MODE_DUPLEX = 1'b1;
    localparam logic [5:0] STEP_DIRECT = 6'h02;
    localparam logic [5:0] STEP_DUPLEX = 6'h01;
    localparam logic [31:0] SEGMENT_RESET = 32'h00000000;

    // ****************************************************************
    // Display timing on the oscillator clock
    // ****************************************************************
    localparam logic [7:0] FRAME_DIV_CYCLES = 8'h10;
    localparam logic [7:0] FRAME_DIV_RESET = 8'h00;
    localparam logic [1:0] SLOT_RESET = 2'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_CTRL = 2'b11,
        ST_DATA = 2'b10
    } bus_state_t;

    typedef struct packed {
        logic mode;
        logic bank;
        logic [7:0][7:0] seg;
    } display_image_t;

    localparam display_image_t IMAGE_RESET = '0;

    // A synchronised bit moves only once the last two stages agree.
    function automatic logic [7:0] agree_filter(input logic [7:0] s2, input logic [7:0] s3,
                                               input logic [7:0] held);
        agree_filter = (s2 & ~(s2 ^ s3)) | (held & (s2 ^ s3));
    endfunction : agree_filter

    // Gathers one byte of each pair, even or odd, onto the 32 segment lines.
    function automatic logic [31:0] pick_bytes(input logic [7:0][7:0] seg, input logic odd);
        logic [31:0] bits;
        bits = '0;
        for (int k = 0; k < 4; k++)
        begin
            bits[8 * k +: 8] = seg[2 * k + (odd ? 1 : 0)];
        end
        pick_bytes = bits;
    endfunction : pick_bytes

endpackage : lcd_loader_pkg

// ### lcd_bus_master_model.sv
// Behavioural two-wire bus master that loads the display store.
`timescale 1ns/10ps

module lcd_bus_master_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    // ********************
    // Bus timing in system clocks
    // ********************
    localparam int HIGH = 15;
    localparam int LOW = 12;
    localparam int HOLD = 4;
    int stretch = 0;

    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    // Data moves only after the clock fall has passed the slave's synchroniser.
    task automatic pulse;
        tick(LOW + stretch);
        scl_o = 1'b1;
        tick(HIGH);
        scl_o = 1'b0;
        tick(HOLD);
    endtask : pulse

    task automatic start_cond;
        sda_o = 1'b1;
        scl_o = 1'b1;
        tick(HIGH);
        sda_o = 1'b0;
        tick(HIGH);
        scl_o = 1'b0;
        tick(HOLD);
    endtask : start_cond

    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            sda_o = b[i];
            pulse();
        end
        sda_o = 1'b1;
        tick(LOW + stretch);
        scl_o = 1'b1;
        tick(HIGH / 2);
        ack = (sda_i === 1'b0);
        tick(HIGH - HIGH / 2);
        scl_o = 1'b0;
        tick(HOLD);
    endtask : send_byte

    task automatic stop_cond;
        sda_o = 1'b0;
        tick(LOW);
        scl_o = 1'b1;
        tick(HIGH);
        sda_o = 1'b1;
        tick(HIGH);
    endtask : stop_cond
endmodule : lcd_bus_master_model

// ### lcd_loader_sva.sv
// Concurrent checks on the ports of the display-store serial loader.
`timescale 1ns/10ps

module lcd_loader_sva (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic osc_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic rc_osc_used_i,
    input wire logic subaddr_low_bit_rc_pin_i,
    input wire logic subaddr_mid_bit_i,
    input wire logic subaddr_high_bit_or_second_backplane_i,
    input wire logic subaddr_high_bit_or_second_backplane_o,
    input wire logic subaddr_high_bit_or_second_backplane_oe_o,
    input wire logic first_backplane_out_i,
    input wire logic first_backplane_out_o,
    input wire logic first_backplane_out_oe_o,
    input wire logic [31:0] segment_o
);
    // ********************
    // Serial side
    // ********************
    a_data_open_drain: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        sda_o == 1'b0) else $error("data line driven high");
    a_ack_reset_clear: assert property (@(posedge sys_clk_i)
        !reset_n_i |=> !sda_oe_o) else $error("acknowledge during reset");
    a_ack_rise_low: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        $rose(sda_oe_o) |-> !scl_i [*3]) else $error("acknowledge began outside clock low");
    a_ack_through_high: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        sda_oe_o && scl_i |=> sda_oe_o) else $error("acknowledge dropped in clock high");
    a_ack_fall_low: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        $fell(sda_oe_o) |-> !scl_i) else $error("acknowledge released in clock high");

    // ********************
    // Display side
    // ********************
    // A long reset is needed because reset reaches this domain through two flops.
    a_seg_reset_zero: assert property (@(posedge osc_clk_i)
        !reset_n_i [*4] |=> segment_o == 32'h00000000 && !first_backplane_out_o)
        else $error("segments not grounded in reset");
    a_bp_oe_reset: assert property (@(posedge osc_clk_i)
        !reset_n_i [*4] |=> !first_backplane_out_oe_o && !subaddr_high_bit_or_second_backplane_oe_o)
        else $error("backplane driven in reset");
    a_bp_exclusive: assert property (@(posedge osc_clk_i) disable iff (!reset_n_i)
        !(first_backplane_out_o && subaddr_high_bit_or_second_backplane_o))
        else $error("both backplanes active");
    a_bp2_master_only: assert property (@(posedge osc_clk_i) disable iff (!reset_n_i)
        subaddr_high_bit_or_second_backplane_oe_o |-> first_backplane_out_oe_o)
        else $error("second backplane driven without master");

    c_ack: cover property (@(posedge sys_clk_i) $rose(sda_oe_o));
    c_duplex: cover property (@(posedge osc_clk_i) $rose(subaddr_high_bit_or_second_backplane_oe_o));
    c_lit: cover property (@(posedge osc_clk_i) first_backplane_out_o && segment_o != 32'h00000000);
endmodule : lcd_loader_sva

bind lcd_segment_loader_serial_slave lcd_loader_sva u_lcd_loader_sva (.sys_clk_i, .reset_n_i,
    .osc_clk_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .rc_osc_used_i, .subaddr_low_bit_rc_pin_i,
    .subaddr_mid_bit_i, .subaddr_high_bit_or_second_backplane_i,
    .subaddr_high_bit_or_second_backplane_o, .subaddr_high_bit_or_second_backplane_oe_o,
    .first_backplane_out_i, .first_backplane_out_o, .first_backplane_out_oe_o, .segment_o);

// ### lcd_segment_loader_serial_slave_tb_top.sv
// Self-checking bench for the display-store serial loader.
`timescale 1ns/10ps

module lcd_segment_loader_serial_slave_tb_top;
    logic sys_clk_i, osc_clk_i, reset_n_i;
    logic scl, sda_m, sda_o, sda_oe_o, bp1_o, bp1_oe, bp2_o, bp2_oe;
    logic [31:0] segment_o;
    wire logic sda_w = sda_m & (sda_oe_o ? sda_o : 1'b1);
    // Undriven shared pins fall to their straps, both low here.
    wire logic bp2_pin = bp2_oe ? bp2_o : 1'b0;
    wire logic bp1_pin = bp1_oe ? bp1_o : 1'b0;
    logic rc_used = 1'b1;
    int err_count = 0;
    int checks = 0;
    int cycles = 0;

    // Pin strapped high while the oscillator is in use still reads subaddress zero.
    lcd_segment_loader_serial_slave u_lcd_segment_loader_serial_slave (.sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i), .osc_clk_i(osc_clk_i), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .rc_osc_used_i(rc_used),
        .subaddr_low_bit_rc_pin_i(1'b1), .subaddr_mid_bit_i(1'b0),
        .subaddr_high_bit_or_second_backplane_i(bp2_pin),
        .subaddr_high_bit_or_second_backplane_o(bp2_o),
        .subaddr_high_bit_or_second_backplane_oe_o(bp2_oe),
        .first_backplane_out_i(bp1_pin), .first_backplane_out_o(bp1_o),
        .first_backplane_out_oe_o(bp1_oe), .segment_o(segment_o));

    lcd_bus_master_model u_lcd_bus_master_model (.clk_i(sys_clk_i), .sda_i(sda_w),
        .scl_o(scl), .sda_o(sda_m));

    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    initial
    begin
        osc_clk_i = 1'b0;
        #3;
        forever #6 osc_clk_i = ~osc_clk_i;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Acks: bit 0 address, bit 1 control, then one bit per data byte.
    task automatic xfer(input logic [7:0] ctrl, input logic [63:0] data, input int n,
                        output logic [9:0] acks);
        logic a;
        acks = '0;
        u_lcd_bus_master_model.start_cond();
        u_lcd_bus_master_model.send_byte({lcd_loader_pkg::SLAVE_ADDR, 1'b0}, a);
        acks[0] = a;
        u_lcd_bus_master_model.send_byte(ctrl, a);
        acks[1] = a;
        for (int i = 0; i < n; i++)
        begin
            u_lcd_bus_master_model.send_byte(data[8 * i +: 8], a);
            acks[2 + i] = a;
        end
        u_lcd_bus_master_model.stop_cond();
    endtask : xfer

    // Waits for the chosen backplane's active phase, where segments show inverted data.
    task automatic disp(input logic sel, input logic [31:0] exp);
        int k;
        k = 0;
        repeat (40) @(posedge osc_clk_i);
        #1;
        while ((sel ? bp2_o : bp1_o) !== 1'b1 && k < 200)
        begin
            @(posedge osc_clk_i);
            #1;
            k++;
        end
        check(segment_o, ~exp);
    endtask : disp

    task automatic test_reset;
        check(segment_o, 32'h00000000);
        check({29'h0, bp1_oe, bp2_oe, sda_oe_o}, 32'h0);
        $display("test reset done");
    endtask : test_reset

    task automatic test_address;
        logic a;
        logic [9:0] acks;
        u_lcd_bus_master_model.start_cond();
        u_lcd_bus_master_model.send_byte({lcd_loader_pkg::SLAVE_ADDR ^ 7'h01, 1'b0}, a);
        u_lcd_bus_master_model.stop_cond();
        check({31'h0, a}, 32'h0);
        u_lcd_bus_master_model.start_cond();
        u_lcd_bus_master_model.send_byte({lcd_loader_pkg::SLAVE_ADDR, 1'b1}, a);
        u_lcd_bus_master_model.stop_cond();
        check({31'h0, a}, 32'h0);
        xfer(8'h00, 64'h0, 0, acks);
        check({22'h0, acks}, 32'h3);
        $display("test address done");
    endtask : test_address

    task automatic test_direct;
        logic [9:0] acks;
        xfer(8'h00, 64'h44332211, 4, acks);
        check({22'h0, acks}, 32'h3F);
        disp(1'b0, 32'h44332211);
        check({31'h0, bp2_o}, 32'h0);
        xfer(8'h01, 64'h88776655, 4, acks);
        disp(1'b0, 32'h44332211);
        xfer(8'h41, 64'h0, 0, acks);
        disp(1'b0, 32'h88776655);
        $display("test direct done");
    endtask : test_direct

    // Starts in another chip and wraps the vector round into this one.
    task automatic test_cross;
        logic [9:0] acks;
        xfer(8'h3C, 64'hDDCCBBAA, 4, acks);
        check({22'h0, acks}, 32'h33);
        disp(1'b0, 32'h4433DDCC);
        $display("test cross done");
    endtask : test_cross

    // Slow bit timing here; vector top bit and bank bit are both set yet ignored.
    task automatic test_duplex;
        logic [9:0] acks;
        u_lcd_bus_master_model.stretch = 20;
        xfer(8'hE0, 64'h0807060504030201, 8, acks);
        u_lcd_bus_master_model.stretch = 0;
        check({22'h0, acks}, 32'h3FF);
        disp(1'b0, 32'h07050301);
        disp(1'b1, 32'h08060402);
        check({31'h0, bp2_oe}, 32'h1);
        $display("test duplex done");
    endtask : test_duplex

    // Strapped oscillator pin: backplanes float, and the strap now gives subaddress one.
    task automatic test_cascade;
        logic [9:0] acks;
        @(posedge sys_clk_i);
        #1;
        rc_used = 1'b0;
        repeat (20) @(posedge sys_clk_i);
        #1;
        check({30'h0, bp1_oe, bp2_oe}, 32'h0);
        xfer(8'h08, 64'hA55A, 2, acks);
        check({22'h0, acks}, 32'hF);
        repeat (10) @(posedge osc_clk_i);
        #1;
        check(segment_o, 32'h0705A55A);
        $display("test cascade done");
    endtask : test_cascade

    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            err_count++;
            $display("BAD %0t timeout", $time);
            summarize();
        end
    end

    initial
    begin
        reset_n_i = 1'b0;
        repeat (10) @(posedge sys_clk_i);
        #1;
        test_reset();
        reset_n_i = 1'b1;
        repeat (12) @(posedge sys_clk_i);
        #1;
        test_address();
        test_direct();
        test_cross();
        test_duplex();
        test_cascade();
        summarize();
    end
endmodule : lcd_segment_loader_serial_slave_tb_top
